// [src/hub_dev.sv]
/*
 device end of the host serial port: wishbone register file, serial engine,
 break reset timer, interrupt status, and the bypass switch to pins 7..4.
 assumes rst_i is the chip reset, and chip_rst_o is fed back into it.
*/
`timescale 1ns/10ps
module hub_dev #(
   parameter logic [31:0] BRK_TO_RST = hub_pkg::BRK_TO_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // system
   output logic irq_o,
   output logic chip_rst_o,
   output logic sleep_o,
   // general purpose pins 7..4 in bits 3..0
   input wire logic [3:0] gp_i,
   output logic [3:0] gp_o,
   output logic [3:0] gp_oe_o,
   // serial link
   hub_if.dev link
);
   // byte-enable write mask, used by the control, break timeout and mask registers
   function automatic logic [31:0] wmask(input logic [3:0] sel);
      wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // bus and registers
   logic ack_q, ack_d, wr, rd;
   logic [31:0] dat_q, dat_d, m;
   logic [7:0] adr;
   logic [20:0] ctrl_q, ctrl_d;
   logic [31:0] brk_to_q, brk_to_d, brk_cnt_q, brk_cnt_d;
   logic [7:0] tx_hold_q, tx_hold_d, rx_q, rx_d;
   logic tx_full_q, tx_full_d, rx_full_q, rx_full_d;
   logic [4:0] sts_q, sts_d, msk_q, msk_d, ev;
   hub_pkg::hub_mode_t mode_q, mode_d;
   logic irq_q, irq_d, crst_q, crst_d, sleep_q, sleep_d;
   // link and pin drivers, enables low in reset so the lines float
   logic txd_q, txd_d, txoe_q, txoe_d, rts_q, rts_d, rtsoe_q, rtsoe_d;
   logic [3:0] gpo_q, gpo_d, gpoe_q, gpoe_d;
   // pin 7 and 6 inputs, three stages and a level
   logic [1:0] g1_q, g2_q, g3_q, gl_q, gl_d;
   // engine connections
   logic tx_take, ser_tx, rx_line, cts_n, rx_valid, rx_perr, rx_ferr;
   logic [7:0] rx_data;
   logic run;

   assign run = mode_q == hub_pkg::HUB_RUN;

   // serial engine, transmit is refused while asleep
   hub_ser u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .divisor_i(ctrl_q[15:0]),
      .parity_i(ctrl_q[hub_pkg::CTRL_PAR_LSB +: 2]),
      .two_stop_i(ctrl_q[hub_pkg::CTRL_TWO_STOP]),
      .flow_en_i(ctrl_q[hub_pkg::CTRL_FLOW]),
      .brk_i(ctrl_q[hub_pkg::CTRL_BREAK] && run),
      .tx_data_i(tx_hold_q),
      .tx_valid_i(tx_full_q && run),
      .tx_idle_o(),
      .tx_take_o(tx_take),
      .tx_o(ser_tx),
      .rx_pin_i(link.dev_rx),
      .cts_n_pin_i(link.dev_cts_n),
      .rx_line_o(rx_line),
      .cts_n_o(cts_n),
      .rx_data_o(rx_data),
      .rx_valid_o(rx_valid),
      .rx_perr_o(rx_perr),
      .rx_ferr_o(rx_ferr)
   );

   // next values of bus, registers, timer, mode and drivers
   always_comb
   begin
      adr = {wb_adr_i[7:2], 2'b00};
      wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
      rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
      m = wmask(wb_sel_i);
      // answer every access one cycle later, unmapped reads give zero
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = 32'h0000_0000;
      case (adr)
         hub_pkg::OFS_CTRL: dat_d = {11'h000, ctrl_q};
         hub_pkg::OFS_BRK_TO: dat_d = brk_to_q;
         hub_pkg::OFS_TXDATA: dat_d = {24'h000000, tx_hold_q};
         hub_pkg::OFS_RXDATA: dat_d = {24'h000000, rx_q};
         hub_pkg::OFS_STATUS: dat_d = {27'h0000000, sts_q};
         hub_pkg::OFS_MASK: dat_d = {27'h0000000, msk_q};
         hub_pkg::OFS_STATE: dat_d = {27'h0000000, rx_line, cts_n, !run, rx_full_q, tx_full_q};
         default: dat_d = 32'h0000_0000;
      endcase
      ctrl_d = ctrl_q;
      brk_to_d = brk_to_q;
      msk_d = msk_q;
      if (wr && adr == hub_pkg::OFS_CTRL)
         ctrl_d = (ctrl_q & ~m[20:0]) | (wb_dat_i[20:0] & m[20:0]);
      if (wr && adr == hub_pkg::OFS_BRK_TO)
         brk_to_d = (brk_to_q & ~m) | (wb_dat_i & m);
      if (wr && adr == hub_pkg::OFS_MASK)
         msk_d = (msk_q & ~m[4:0]) | (wb_dat_i[4:0] & m[4:0]);
      // one holding word: a write while it is full is dropped
      tx_hold_d = tx_hold_q;
      tx_full_d = tx_full_q && !tx_take;
      if (wr && adr == hub_pkg::OFS_TXDATA && wb_sel_i[0] && !tx_full_q)
      begin
         tx_hold_d = wb_dat_i[7:0];
         tx_full_d = 1'b1;
      end
      // reading the data clears full, a byte arriving then keeps it set
      rx_d = rx_valid ? rx_data : rx_q;
      rx_full_d = rx_valid || (rx_full_q && !(rd && adr == hub_pkg::OFS_RXDATA));
      // sticky events, write one to clear, a new event beats the clear
      ev = '0;
      ev[hub_pkg::EV_RX] = rx_valid;
      ev[hub_pkg::EV_TX] = tx_take;
      ev[hub_pkg::EV_PERR] = rx_valid && rx_perr;
      ev[hub_pkg::EV_FERR] = rx_valid && rx_ferr;
      ev[hub_pkg::EV_BRK] = rx_valid && rx_ferr && rx_data == 8'h00;
      sts_d = sts_q;
      if (wr && adr == hub_pkg::OFS_STATUS && wb_sel_i[0])
         sts_d = sts_q & ~wb_dat_i[4:0];
      sts_d = sts_d | ev;
      irq_d = |(sts_q & msk_q);
      // break timer: low cycles counted, cleared as soon as the line is high
      brk_cnt_d = 32'h0000_0000;
      crst_d = 1'b0;
      if (!rx_line && run)
      begin
         brk_cnt_d = (brk_cnt_q == 32'hFFFF_FFFF) ? brk_cnt_q : 32'(brk_cnt_q + 32'h1);
         crst_d = brk_cnt_q == brk_to_q;
      end
      // bypass is entered by command and left only by reset
      mode_d = mode_q;
      if (wr && adr == hub_pkg::OFS_CMD && wb_sel_i[0] && wb_dat_i[7:0] == hub_pkg::CMD_BYPASS)
         mode_d = hub_pkg::HUB_BYP;
      sleep_d = mode_q == hub_pkg::HUB_BYP;
      // after reset the host lines are owned by the internal port
      txoe_d = 1'b1;
      rtsoe_d = 1'b1;
      gl_d = (~(g2_q ^ g3_q) & g3_q) | ((g2_q ^ g3_q) & gl_q);
      case (mode_q)
         hub_pkg::HUB_RUN:
         begin
            txd_d = ser_tx;
            // ready to take a byte while the data word is empty
            rts_d = ctrl_q[hub_pkg::CTRL_FLOW] && rx_full_q;
            gpo_d = 4'h0;
            gpoe_d = 4'h0;
         end
         hub_pkg::HUB_BYP:
         begin
            // pass through: host tx, rts to pins 4, 5; pins 6, 7 back to host
            txd_d = gl_q[0];
            rts_d = gl_q[1];
            gpo_d = {2'b00, cts_n, rx_line};
            gpoe_d = 4'h3;
         end
         default:
         begin
            txd_d = 1'b1;
            rts_d = 1'b1;
            gpo_d = 4'h0;
            gpoe_d = 4'h0;
         end
      endcase
   end

   // register everything; reset releases the serial and pin drivers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         ctrl_q <= hub_pkg::CTRL_RST;
         brk_to_q <= BRK_TO_RST;
         brk_cnt_q <= 32'h0000_0000;
         tx_hold_q <= 8'h00;
         tx_full_q <= 1'b0;
         rx_q <= 8'h00;
         rx_full_q <= 1'b0;
         sts_q <= 5'h00;
         msk_q <= 5'h00;
         mode_q <= hub_pkg::HUB_RUN;
         irq_q <= 1'b0;
         crst_q <= 1'b0;
         sleep_q <= 1'b0;
         txd_q <= 1'b1;
         txoe_q <= 1'b0;
         rts_q <= 1'b1;
         rtsoe_q <= 1'b0;
         gpo_q <= 4'h0;
         gpoe_q <= 4'h0;
         g1_q <= 2'h3;
         g2_q <= 2'h3;
         g3_q <= 2'h3;
         gl_q <= 2'h3;
      end
      else if (ce_i)
      begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         ctrl_q <= ctrl_d;
         brk_to_q <= brk_to_d;
         brk_cnt_q <= brk_cnt_d;
         tx_hold_q <= tx_hold_d;
         tx_full_q <= tx_full_d;
         rx_q <= rx_d;
         rx_full_q <= rx_full_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
         mode_q <= mode_d;
         irq_q <= irq_d;
         crst_q <= crst_d;
         sleep_q <= sleep_d;
         txd_q <= txd_d;
         txoe_q <= txoe_d;
         rts_q <= rts_d;
         rtsoe_q <= rtsoe_d;
         gpo_q <= gpo_d;
         gpoe_q <= gpoe_d;
         g1_q <= gp_i[3:2];
         g2_q <= g1_q;
         g3_q <= g2_q;
         gl_q <= gl_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = irq_q;
   assign chip_rst_o = crst_q;
   assign sleep_o = sleep_q;
   assign gp_o = gpo_q;
   assign gp_oe_o = gpoe_q;
   assign link.dev_tx = txd_q;
   assign link.dev_tx_oe = txoe_q;
   assign link.dev_rts_n = rts_q;
   assign link.dev_rts_oe = rtsoe_q;
endmodule

// [src/hub_pkg.sv]
/*
 constants shared by both ends of the host serial port: timing, register map,
 field positions, reset values, frame options and the device's mode type.
 assumes a single 20 MHz clock on both ends.
*/
package hub_pkg;
   // clock and baud scale
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BAUD_SCALE_US = 4096; // 0.004096 s
   // clock cycles per bit times divisor, 81920 at 20 MHz
   localparam logic [17:0] BIT_NUM = 18'(64'(CLK_HZ) * 64'(BAUD_SCALE_US) / 64'd1_000_000);
   localparam logic [17:0] BIT_HALF = 18'(BIT_NUM >> 1);
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BRK_TO = 8'h04;
   localparam logic [7:0] OFS_TXDATA = 8'h08;
   localparam logic [7:0] OFS_RXDATA = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_CMD = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;
   // control field positions
   localparam int unsigned CTRL_PAR_LSB = 16;
   localparam int unsigned CTRL_TWO_STOP = 18;
   localparam int unsigned CTRL_FLOW = 19;
   localparam int unsigned CTRL_BREAK = 20;
   localparam int unsigned CTRL_W = 21;
   // reset values
   localparam logic [20:0] CTRL_RST = 21'h0001D8; // divisor 472, 8N1, no flow
   localparam logic [31:0] BRK_TO_DEF = 32'h0001_0000; // cycles of low line
   // event bits of status and mask
   localparam int unsigned EV_RX = 0;
   localparam int unsigned EV_TX = 1;
   localparam int unsigned EV_PERR = 2;
   localparam int unsigned EV_FERR = 3;
   localparam int unsigned EV_BRK = 4;
   localparam int unsigned EV_W = 5;
   // host control command codes
   localparam logic [7:0] CMD_BYPASS = 8'h01;
   // parity encodings
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   // device connection mode
   typedef enum logic [1:0] {HUB_RUN = 2'b01, HUB_BYP = 2'b10} hub_mode_t;
endpackage

// [src/hub_if.sv]
/*
 serial link between the device end and the host end.
 each end gives level and enable per line; idle lines read as high (pull-up).
*/
`timescale 1ns/10ps
interface hub_if;
   // device drive
   logic dev_tx;
   logic dev_tx_oe;
   logic dev_rts_n;
   logic dev_rts_oe;
   // host drive
   logic host_tx;
   logic host_tx_oe;
   logic host_rts_n;
   logic host_rts_oe;
   // resolved wire levels, a floating line pulls high
   logic dev_rx;
   logic dev_cts_n;
   logic host_rx;
   logic host_cts_n;
   assign dev_rx = host_tx_oe ? host_tx : 1'b1;
   assign dev_cts_n = host_rts_oe ? host_rts_n : 1'b1;
   assign host_rx = dev_tx_oe ? dev_tx : 1'b1;
   assign host_cts_n = dev_rts_oe ? dev_rts_n : 1'b1;
   modport dev (output dev_tx, dev_tx_oe, dev_rts_n, dev_rts_oe, input dev_rx, dev_cts_n);
   modport host (output host_tx, host_tx_oe, host_rts_n, host_rts_oe, input host_rx, host_cts_n);
endinterface

// [src/hub_ser.sv]
/*
 serial frame engine: one transmitter, one receiver, line synchronisers.
 assumes divisor nonzero; both directions share the frame settings.
*/
`timescale 1ns/10ps
module hub_ser (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // frame settings
   input wire logic [15:0] divisor_i,
   input wire logic [1:0] parity_i,
   input wire logic two_stop_i,
   input wire logic flow_en_i,
   input wire logic brk_i,
   // transmit side
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_idle_o,
   output logic tx_take_o,
   output logic tx_o,
   // receive side
   input wire logic rx_pin_i,
   input wire logic cts_n_pin_i,
   output logic rx_line_o,
   output logic cts_n_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_perr_o,
   output logic rx_ferr_o
);
   // synchroniser stages, bit 0 receive, bit 1 clear-to-send
   logic [1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;
   // transmitter
   logic [3:0] tx_cnt_q, tx_cnt_d;
   logic [11:0] tx_sh_q, tx_sh_d;
   logic [17:0] tx_acc_q, tx_acc_d, tx_sum;
   logic tx_q, tx_d;
   // receiver
   logic [3:0] rx_cnt_q, rx_cnt_d;
   logic [10:0] rx_sh_q, rx_sh_d;
   logic [17:0] rx_acc_q, rx_acc_d, rx_sum;
   logic [7:0] rx_data_q, rx_data_d;
   logic rx_valid_q, rx_valid_d, rx_perr_q, rx_perr_d, rx_ferr_q, rx_ferr_d;
   logic par_en, odd;

   // next state of synchronisers, transmitter and receiver
   always_comb
   begin
      s1_d = {cts_n_pin_i, rx_pin_i};
      s2_d = s1_q;
      s3_d = s2_q;
      // a change counts once stages two and three agree
      lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
      par_en = parity_i != hub_pkg::PAR_NONE;
      odd = parity_i == hub_pkg::PAR_ODD;
      // fractional accumulator: one bit per BIT_NUM/divisor cycles
      tx_sum = 18'(tx_acc_q + 18'(divisor_i));
      rx_sum = 18'(rx_acc_q + 18'(divisor_i));
      tx_cnt_d = tx_cnt_q;
      tx_sh_d = tx_sh_q;
      tx_acc_d = tx_acc_q;
      tx_take_o = 1'b0;
      if (tx_cnt_q == 4'h0)
      begin
         tx_acc_d = '0;
         // with flow on, start only while the partner shows clear-to-send low
         if (tx_valid_i && !brk_i && (!flow_en_i || !lvl_q[1]))
         begin
            tx_take_o = 1'b1;
            tx_sh_d = {2'b11, par_en ? (^tx_data_i ^ odd) : 1'b1, tx_data_i, 1'b0};
            tx_cnt_d = 4'hA + {3'h0, par_en} + {3'h0, two_stop_i};
         end
      end
      else if (tx_sum >= hub_pkg::BIT_NUM)
      begin
         tx_acc_d = 18'(tx_sum - hub_pkg::BIT_NUM);
         tx_sh_d = {1'b1, tx_sh_q[11:1]};
         tx_cnt_d = 4'(tx_cnt_q - 4'h1);
      end
      else
         tx_acc_d = tx_sum;
      // break overrides the line while asked for
      tx_d = brk_i ? 1'b0 : ((tx_cnt_d != 4'h0) ? tx_sh_d[0] : 1'b1);
      rx_cnt_d = rx_cnt_q;
      rx_sh_d = rx_sh_q;
      rx_acc_d = rx_acc_q;
      rx_valid_d = 1'b0;
      rx_data_d = rx_data_q;
      rx_perr_d = rx_perr_q;
      rx_ferr_d = rx_ferr_q;
      if (rx_cnt_q == 4'h0)
      begin
         // falling edge starts a frame, first sample at mid start bit
         if (lvl_q[0] && !lvl_d[0])
         begin
            rx_cnt_d = 4'hA + {3'h0, par_en};
            rx_acc_d = hub_pkg::BIT_HALF;
         end
      end
      else if (rx_sum >= hub_pkg::BIT_NUM)
      begin
         rx_acc_d = 18'(rx_sum - hub_pkg::BIT_NUM);
         rx_sh_d = {lvl_q[0], rx_sh_q[10:1]};
         rx_cnt_d = 4'(rx_cnt_q - 4'h1);
         if (rx_cnt_q == 4'h1)
         begin
            // only the first stop bit is checked, a second one is idle time
            rx_valid_d = 1'b1;
            rx_data_d = par_en ? rx_sh_d[8:1] : rx_sh_d[9:2];
            rx_ferr_d = !rx_sh_d[10];
            rx_perr_d = par_en && ((^rx_sh_d[9:1]) != odd);
         end
      end
      else
         rx_acc_d = rx_sum;
   end

   // register all engine state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         s3_q <= 2'h3;
         lvl_q <= 2'h3;
         tx_cnt_q <= 4'h0;
         tx_sh_q <= 12'hFFF;
         tx_acc_q <= '0;
         tx_q <= 1'b1;
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 11'h7FF;
         rx_acc_q <= '0;
         rx_data_q <= 8'h00;
         rx_valid_q <= 1'b0;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
      end
      else if (ce_i)
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
         tx_cnt_q <= tx_cnt_d;
         tx_sh_q <= tx_sh_d;
         tx_acc_q <= tx_acc_d;
         tx_q <= tx_d;
         rx_cnt_q <= rx_cnt_d;
         rx_sh_q <= rx_sh_d;
         rx_acc_q <= rx_acc_d;
         rx_data_q <= rx_data_d;
         rx_valid_q <= rx_valid_d;
         rx_perr_q <= rx_perr_d;
         rx_ferr_q <= rx_ferr_d;
      end
   end

   assign tx_idle_o = tx_cnt_q == 4'h0;
   assign tx_o = tx_q;
   assign rx_line_o = lvl_q[0];
   assign cts_n_o = lvl_q[1];
   assign rx_data_o = rx_data_q;
   assign rx_valid_o = rx_valid_q;
   assign rx_perr_o = rx_perr_q;
   assign rx_ferr_o = rx_ferr_q;
endmodule

// [src/hub_host.sv]
/*
 host end of the serial link: frames bytes to and from the device.
 assumes the user holds drive_en_i low while the device is in reset.
*/
`timescale 1ns/10ps
module hub_host (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // frame settings, must match the device
   input wire logic [15:0] divisor_i,
   input wire logic [1:0] parity_i,
   input wire logic two_stop_i,
   input wire logic flow_en_i,
   input wire logic drive_en_i,
   input wire logic brk_i,
   // user byte streams
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_take_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_perr_o,
   output logic rx_ferr_o,
   // serial link
   hub_if.host link
);
   logic ser_tx;
   logic tx_q, oe_q, rts_q, rtsoe_q;

   // shared frame engine
   hub_ser u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .divisor_i(divisor_i),
      .parity_i(parity_i),
      .two_stop_i(two_stop_i),
      .flow_en_i(flow_en_i),
      .brk_i(brk_i),
      .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i && drive_en_i),
      .tx_idle_o(),
      .tx_take_o(tx_take_o),
      .tx_o(ser_tx),
      .rx_pin_i(link.host_rx),
      .cts_n_pin_i(link.host_cts_n),
      .rx_line_o(),
      .cts_n_o(),
      .rx_data_o(rx_data_o),
      .rx_valid_o(rx_valid_o),
      .rx_perr_o(rx_perr_o),
      .rx_ferr_o(rx_ferr_o)
   );

   // drivers float whenever the user releases the bus
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_q <= 1'b1;
         oe_q <= 1'b0;
         rts_q <= 1'b1;
         rtsoe_q <= 1'b0;
      end
      else if (ce_i)
      begin
         tx_q <= ser_tx;
         oe_q <= drive_en_i;
         rts_q <= flow_en_i && !rx_ready_i;
         rtsoe_q <= drive_en_i;
      end
   end

   assign link.host_tx = tx_q;
   assign link.host_tx_oe = oe_q;
   assign link.host_rts_n = rts_q;
   assign link.host_rts_oe = rtsoe_q;
endmodule

// [testbench/hub_assertions.sv]
/*
 checker for the serial link between the device end and the host end.
 assumes the bench runs the link at 5 clock cycles per bit.
*/
`timescale 1ns/10ps
module hub_assertions (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link signals
   input wire logic dev_tx,
   input wire logic dev_tx_oe,
   input wire logic dev_rts_n,
   input wire logic dev_rts_oe,
   input wire logic host_tx_oe,
   input wire logic host_rts_oe,
   input wire logic host_rx
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a bit edge on the device's line, start of one bit time
   sequence s_bit_low;
      $fell(host_rx);
   endsequence
   sequence s_bit_high;
      $rose(host_rx);
   endsequence
   // reset itself is the cause here, so these three are never disabled
   chk_rst_float_out: assert property (disable iff (1'b0) rst_i |=> !dev_tx_oe && !dev_rts_oe)
      else $error("device drives the link in reset");
   chk_rst_idle_lvl: assert property (disable iff (1'b0) rst_i |=> dev_tx && dev_rts_n)
      else $error("device lines not idle in reset");
   chk_host_let_go: assert property (disable iff (1'b0) rst_i ##1 rst_i |-> !host_tx_oe && !host_rts_oe)
      else $error("host drives the link in device reset");
   chk_run_drive_on: assert property (!rst_i ##1 !rst_i |-> dev_tx_oe && dev_rts_oe)
      else $error("device not on the link after reset");
   chk_dev_oe_pair: assert property (dev_tx_oe == dev_rts_oe)
      else $error("device enables differ");
   chk_host_oe_pair: assert property (host_tx_oe == host_rts_oe)
      else $error("host enables differ");
   chk_low_bit_len: assert property (s_bit_low |-> !host_rx [*5])
      else $error("low bit shorter than a bit time");
   chk_high_bit_len: assert property (s_bit_high |-> host_rx [*5])
      else $error("high bit shorter than a bit time");
endmodule

// [testbench/host_uart_with_break_and_bypass_tb.sv]
/*
 bench: both ends joined by the link; wishbone master on the device,
 bytes both ways in every parity and flow setting (device sends 00, FF, then random), break, interrupt and bypass.
 assumes a 20 MHz clock; divisor 16384 gives 5 cycles per bit.
*/
`timescale 1ns/10ps
module host_uart_with_break_and_bypass_tb;
   localparam logic [31:0] BRK_TO = 32'd200; // short break timeout
   localparam logic [15:0] DIV = 16'h4000; // 5 cycles per bit
   logic clk_i = 1'b0;
   logic rst_i = 1'b1; // bench reset
   logic dev_rst; // chip reset, also from a long break
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic ack, irq, chip_rst, sleep;
   logic [3:0] gp_i = 4'hF, gp_o, gp_oe;
   logic [1:0] par = 2'h0;
   logic stop2 = 1'b0, flow = 1'b0, hbrk = 1'b0, htv = 1'b0, ce = 1'b1;
   logic [7:0] htd = 8'h0, hrd;
   logic htake, hrv, hpe, hfe;
   int fail_count = 0, tests_run = 0, cycles = 0, cnt;
   hub_if i_hub_if ();
   assign dev_rst = rst_i | chip_rst;
   hub_dev #(.BRK_TO_RST(BRK_TO)) i_hub_dev (.clk_i(clk_i), .rst_i(dev_rst), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .chip_rst_o(chip_rst),
      .sleep_o(sleep), .gp_i(gp_i), .gp_o(gp_o), .gp_oe_o(gp_oe), .link(i_hub_if.dev));
   // host lets go of the link while the device is in reset
   hub_host i_hub_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .divisor_i(DIV),
      .parity_i(par), .two_stop_i(stop2), .flow_en_i(flow), .drive_en_i(!dev_rst),
      .brk_i(hbrk), .tx_data_i(htd), .tx_valid_i(htv), .tx_take_o(htake), .rx_ready_i(1'b1),
      .rx_data_o(hrd), .rx_valid_o(hrv), .rx_perr_o(hpe), .rx_ferr_o(hfe), .link(i_hub_if.host));
   hub_assertions i_hub_assertions (.clk_i(clk_i), .rst_i(dev_rst),
      .dev_tx(i_hub_if.dev_tx), .dev_tx_oe(i_hub_if.dev_tx_oe), .dev_rts_n(i_hub_if.dev_rts_n),
      .dev_rts_oe(i_hub_if.dev_rts_oe), .host_tx_oe(i_hub_if.host_tx_oe),
      .host_rts_oe(i_hub_if.host_rts_oe), .host_rx(i_hub_if.host_rx));
   // free running clock, 50 ns period
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   // hang guard, well above the longest expected run
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one classic wishbone cycle; read data lands in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // expected control word for a frame mode
   function automatic logic [31:0] exp_ctrl(input logic [1:0] p, input logic s, input logic f);
      return 32'(DIV) | (32'(p) << hub_pkg::CTRL_PAR_LSB) | (32'(s) << hub_pkg::CTRL_TWO_STOP)
         | (32'(f) << hub_pkg::CTRL_FLOW);
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial
   begin
      void'($urandom(81533));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, hub_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h000001D8, rd);
      wb(1'b0, hub_pkg::OFS_BRK_TO, 32'h0);
      chk("break timeout", BRK_TO, rd);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, hub_pkg::OFS_MASK, 32'h1);
      // every parity, flow off then on, random stop count and bytes
      for (int m = 0; m < 6; m++)
      begin
         logic [1:0] p;
         logic s, f;
         logic [7:0] b;
         p = 2'(m % 3);
         s = 1'($urandom_range(1));
         f = 1'(m / 3);
         par <= p;
         stop2 <= s;
         flow <= f;
         wb(1'b1, hub_pkg::OFS_CTRL, exp_ctrl(p, s, f));
         wb(1'b0, hub_pkg::OFS_CTRL, 32'h0);
         chk("ctrl mode", exp_ctrl(p, s, f), rd);
         b = (m == 0) ? 8'h00 : (m == 1) ? 8'hFF : 8'($urandom);
         wb(1'b1, hub_pkg::OFS_TXDATA, 32'(b));
         do @(posedge clk_i); while (hrv !== 1'b1);
         chk("host rx", 32'(b), {22'h0, hpe, hfe, hrd});
         b = 8'($urandom);
         htd <= b;
         htv <= 1'b1;
         do @(posedge clk_i); while (htake !== 1'b1);
         htv <= 1'b0;
         do @(posedge clk_i); while (irq !== 1'b1);
         wb(1'b0, hub_pkg::OFS_RXDATA, 32'h0);
         chk("dev rx", 32'(b), rd);
         wb(1'b0, hub_pkg::OFS_STATUS, 32'h0);
         chk("status", 32'h3, rd);
         wb(1'b1, hub_pkg::OFS_STATUS, 32'h1F);
         @(posedge clk_i);
         chk("irq clear", 32'h0, 32'(irq));
      end
      // masked event leaves the interrupt low
      wb(1'b1, hub_pkg::OFS_MASK, 32'h0);
      htv <= 1'b1;
      do @(posedge clk_i); while (htake !== 1'b1);
      htv <= 1'b0;
      do wb(1'b0, hub_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b1);
      chk("irq masked", 32'h0, 32'(irq));
      // device sends a break
      wb(1'b1, hub_pkg::OFS_CTRL, exp_ctrl(par, stop2, flow) | 32'h00100000);
      repeat (100) @(posedge clk_i);
      chk("dev break", 32'h0, 32'(i_hub_if.host_rx));
      wb(1'b1, hub_pkg::OFS_CTRL, exp_ctrl(par, stop2, flow));
      repeat (20) @(posedge clk_i);
      // short low then a long one; only the long one resets the chip
      hbrk <= 1'b1;
      cnt = 0;
      repeat (150) @(posedge clk_i) cnt += int'(chip_rst === 1'b1);
      hbrk <= 1'b0;
      repeat (10) @(posedge clk_i);
      // the low line framed as a zero character: rx, framing and break bits
      wb(1'b0, hub_pkg::OFS_STATUS, 32'h0);
      chk("break event", 32'h19, rd);
      hbrk <= 1'b1;
      chk("short break", 32'h0, 32'(cnt));
      cnt = 0;
      do
      begin
         @(posedge clk_i);
         cnt++;
      end
      while (chip_rst !== 1'b1);
      hbrk <= 1'b0;
      chk("break time", 32'h1, 32'(cnt > 200 && cnt < 220));
      repeat (3) @(posedge clk_i);
      wb(1'b0, hub_pkg::OFS_CTRL, 32'h0);
      chk("ctrl after break", 32'h000001D8, rd);
      // bypass: host lines pass through pins 7..4, device sleeps
      wb(1'b1, hub_pkg::OFS_CMD, 32'(hub_pkg::CMD_BYPASS));
      repeat (3) @(posedge clk_i);
      chk("sleep", 32'h1, 32'(sleep));
      chk("pin enables", 32'h3, 32'(gp_oe));
      // enable low freezes the pass-through, so a pin change must not show
      ce <= 1'b0;
      gp_i <= 4'h0;
      repeat (10) @(posedge clk_i);
      chk("frozen", 32'h1, 32'(i_hub_if.host_rx));
      ce <= 1'b1;
      repeat (8)
      begin
         gp_i <= 4'($urandom);
         hbrk <= 1'($urandom);
         repeat (10) @(posedge clk_i);
         chk("pins to host", 32'(gp_i[3:2]), 32'({i_hub_if.host_cts_n, i_hub_if.host_rx}));
         chk("host to pins", 32'(!hbrk), 32'(gp_o));
         chk("still asleep", 32'h1, 32'(sleep));
      end
      hbrk <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("awake after reset", 32'h0, {27'h0, sleep, gp_oe});
      finish_test();
   end
endmodule
